// >>> hdl/acr_chan_path.sv
// One channel's output path: offset trim, test patterns and output coding
`timescale 1ns/1ps
`default_nettype none
module acr_chan_path
  import acr_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Settings and timing
  input wire acr_pkg::acr_chan_cfg_s cfg_i,
  input wire logic sample_en_i,
  input wire logic hold_i,
  // Data
  input wire logic [13:0] conv_data_i,
  output logic [13:0] out_data_o
);
  logic [22:0] pn_long_reg;
  logic [8:0] pn_short_reg;
  logic phase_reg;
  logic [13:0] pattern;
  wire logic signed [15:0] trimmed;
  wire logic [13:0] clipped;
  wire logic [13:0] coded;

  function automatic logic [13:0] to_gray(input logic [13:0] v);
    to_gray = v ^ (v >> 1);
  endfunction

  // Signed trim added to the result, clipped at the code range
  assign trimmed = $signed({2'b00, conv_data_i}) + $signed({{8{cfg_i.offset[7]}}, cfg_i.offset});
  assign clipped = trimmed[15] ? WORD_NEG_FS : (trimmed > 16'sh3fff) ? WORD_POS_FS
    : trimmed[13:0];

  always_comb
  begin
    case (cfg_i.test_mode)
      TEST_OFF: pattern = clipped;
      TEST_MIDSCALE: pattern = WORD_MIDSCALE;
      TEST_POS_FS: pattern = WORD_POS_FS;
      TEST_NEG_FS: pattern = WORD_NEG_FS;
      TEST_CHECKER: pattern = phase_reg ? WORD_CHECKER_B : WORD_CHECKER_A;
      TEST_PN_LONG: pattern = pn_long_reg[13:0];
      TEST_PN_SHORT: pattern = {pn_short_reg[4:0], pn_short_reg};
      TEST_TOGGLE: pattern = phase_reg ? WORD_NEG_FS : WORD_POS_FS;
      default: pattern = clipped;
    endcase
  end

  assign coded = (cfg_i.format == FMT_TWOS_COMP) ? {~pattern[13], pattern[12:0]}
    : (cfg_i.format == FMT_GRAY) ? to_gray(pattern) : pattern;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      pn_long_reg <= PN_LONG_SEED;
      pn_short_reg <= PN_SHORT_SEED;
      phase_reg <= 1'b0;
      out_data_o <= 14'h0000;
    end
    else
    begin
      // Each generator has its own reset bit
      if (cfg_i.pn_long_rst)
        pn_long_reg <= PN_LONG_SEED;
      else if (sample_en_i)
        pn_long_reg <= {pn_long_reg[21:0], pn_long_reg[22] ^ pn_long_reg[17]};
      if (cfg_i.pn_short_rst)
        pn_short_reg <= PN_SHORT_SEED;
      else if (sample_en_i)
        pn_short_reg <= {pn_short_reg[7:0], pn_short_reg[8] ^ pn_short_reg[4]};
      if (sample_en_i)
        phase_reg <= ~phase_reg;
      // A powered-down channel freezes its last word
      if (sample_en_i && !hold_i)
        out_data_o <= cfg_i.invert ? ~coded : coded;
    end
  end
endmodule
`default_nettype wire

// >>> hdl/acr_clk_div.sv
// Sample clock divider producing a sample enable and the stabilizer request
`timescale 1ns/1ps
`default_nettype none
module acr_clk_div
  import acr_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Settings
  input wire logic [2:0] div_code_i,
  input wire logic dcs_bit_i,
  // Results
  output logic sample_en_o,
  output logic dcs_en_o
);
  logic [2:0] count_reg;
  logic [2:0] count_next;
  wire logic wrap;

  // Divide by code plus one
  assign wrap = (count_reg >= div_code_i);
  assign count_next = wrap ? 3'h0 : count_reg + 3'h1;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      count_reg <= 3'h0;
      sample_en_o <= 1'b0;
      dcs_en_o <= 1'b1;
    end
    else
    begin
      count_reg <= count_next;
      sample_en_o <= wrap;
      dcs_en_o <= dcs_bit_i | (div_code_i != 3'h0);
    end
  end
endmodule
`default_nettype wire

// >>> hdl/acr_pkg.sv
// Shared constants, field positions and carrier types for the channel control bank
package acr_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_POWER_MODE = 8'h08;
  localparam logic [7:0] ADDR_GLOBAL_CLOCK = 8'h09;
  localparam logic [7:0] ADDR_CLOCK_DIVIDE = 8'h0b;
  localparam logic [7:0] ADDR_OUTPUT_TEST = 8'h0d;
  localparam logic [7:0] ADDR_SELF_TEST = 8'h0e;
  localparam logic [7:0] ADDR_INPUT_SERVO = 8'h0f;
  localparam logic [7:0] ADDR_OFFSET_TRIM = 8'h10;
  localparam logic [7:0] ADDR_OUTPUT_FORMAT = 8'h14;

  // Reset values
  localparam logic [7:0] RST_POWER_MODE = 8'h80;
  localparam logic [7:0] RST_GLOBAL_CLOCK = 8'h01;
  localparam logic [7:0] RST_CLOCK_DIVIDE = 8'h00;
  localparam logic [7:0] RST_OUTPUT_TEST = 8'h00;
  localparam logic [7:0] RST_SELF_TEST = 8'h04;
  localparam logic [7:0] RST_INPUT_SERVO = 8'h00;
  localparam logic [7:0] RST_OFFSET_TRIM = 8'h00;
  localparam logic [7:0] RST_OUTPUT_FORMAT = 8'h00;

  // Field positions
  localparam int PWR_FIXED_BIT = 7;
  localparam int PWR_PIN_SEL_BIT = 5;
  localparam int CLK_DCS_BIT = 0;
  localparam int TST_PN_LONG_RST_BIT = 5;
  localparam int TST_PN_SHORT_RST_BIT = 4;
  localparam int BIST_RESET_BIT = 2;
  localparam int SELF_TEST_CONTROL_BIT = 0;
  localparam int SERVO_ENABLE_BIT = 0;
  localparam int FMT_DRIVE_BIT = 7;
  localparam int FMT_TYPE_BIT = 6;
  localparam int FMT_INTERLEAVE_BIT = 5;
  localparam int FMT_OE_N_BIT = 4;
  localparam int FMT_INVERT_BIT = 2;

  // Masks of the bits kept per channel and of the bits shared by both channels in the output format register
  localparam logic [7:0] FMT_LOCAL_MASK = 8'h17;
  localparam logic [7:0] FMT_GLOBAL_MASK = 8'he0;

  // Sample width and fixed output words (offset binary)
  localparam int SAMPLE_W = 14;
  localparam logic [13:0] WORD_MIDSCALE = 14'h2000;
  localparam logic [13:0] WORD_POS_FS = 14'h3fff;
  localparam logic [13:0] WORD_NEG_FS = 14'h0000;
  localparam logic [13:0] WORD_CHECKER_A = 14'h2aaa;
  localparam logic [13:0] WORD_CHECKER_B = 14'h1555;
  localparam logic [22:0] PN_LONG_SEED = 23'h7f_ffff;
  localparam logic [8:0] PN_SHORT_SEED = 9'h1ff;

  typedef enum logic [1:0] {
    PWR_NORMAL = 2'b00,
    PWR_SHUTDOWN = 2'b01,
    PWR_STANDBY = 2'b10,
    PWR_NORMAL_ALT = 2'b11
  } acr_power_e;

  typedef enum logic [2:0] {
    TEST_OFF = 3'b000,
    TEST_MIDSCALE = 3'b001,
    TEST_POS_FS = 3'b010,
    TEST_NEG_FS = 3'b011,
    TEST_CHECKER = 3'b100,
    TEST_PN_LONG = 3'b101,
    TEST_PN_SHORT = 3'b110,
    TEST_TOGGLE = 3'b111
  } acr_test_e;

  typedef enum logic [1:0] {
    FMT_OFFSET_BIN = 2'b00,
    FMT_TWOS_COMP = 2'b01,
    FMT_GRAY = 2'b10,
    FMT_OFFSET_ALT = 2'b11
  } acr_format_e;

  // Per-channel settings handed to the data path
  typedef struct packed {
    acr_test_e test_mode;
    logic pn_long_rst;
    logic pn_short_rst;
    logic [7:0] offset;
    acr_format_e format;
    logic invert;
  } acr_chan_cfg_s;

endpackage

// >>> hdl/acr_top.sv
// Channel control register bank for a dual-channel converter
`timescale 1ns/1ps
`default_nettype none
module acr_top
  import acr_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Register port
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [1:0] chan_sel_i,
  output logic [7:0] reg_rdata_o,
  // Power-down pin
  input wire logic pdwn_pin_i,
  // Converter data in and out
  input wire logic [13:0] conv_data_a_i,
  input wire logic [13:0] conv_data_b_i,
  output logic [13:0] out_data_a_o,
  output logic [13:0] out_data_b_o,
  // Per-channel state
  output logic [1:0] shutdown_o,
  output logic [1:0] standby_o,
  output logic [1:0] out_enable_n_o,
  // Global controls
  output logic sample_en_o,
  output logic dcs_en_o,
  output logic bist_en_o,
  output logic bist_reset_o,
  output logic servo_en_o,
  output logic drive_reduced_o,
  output logic output_lvds_o,
  output logic interleave_o
);
  import acr_pkg::*;

  // Local registers, one copy per channel
  logic [7:0] power_mode_control_reg [2];
  logic [7:0] output_test_control_reg [2];
  logic [7:0] offset_trim_reg [2];
  logic [7:0] format_local_reg [2];

  // Global registers
  logic [7:0] global_clock_control_reg;
  logic [7:0] clock_divide_control_reg;
  logic [7:0] self_test_control_reg;
  logic [7:0] input_servo_control_reg;
  logic [7:0] format_global_reg;

  // Address decode
  wire logic hit_power;
  wire logic hit_clock;
  wire logic hit_divide;
  wire logic hit_test;
  wire logic hit_bist;
  wire logic hit_servo;
  wire logic hit_trim;
  wire logic hit_format;
  wire logic rd_chan;
  logic [7:0] rdata_next;

  // Internal wires
  wire logic div_sample_en;
  wire logic div_dcs_en;
  wire logic [13:0] path_data [2];
  wire logic [1:0] shutdown_next;
  wire logic [1:0] standby_next;
  acr_chan_cfg_s chan_cfg [2];

  function automatic logic is_shutdown(input logic [7:0] pwr, input logic pin);
    // Pin acts as shutdown only when its select bit is clear
    is_shutdown = (acr_power_e'(pwr[1:0]) == PWR_SHUTDOWN)
      || (pin && !pwr[PWR_PIN_SEL_BIT]);
  endfunction

  function automatic logic is_standby(input logic [7:0] pwr, input logic pin);
    is_standby = !is_shutdown(pwr, pin)
      && ((acr_power_e'(pwr[1:0]) == PWR_STANDBY)
      || (pin && pwr[PWR_PIN_SEL_BIT]));
  endfunction

  assign hit_power = reg_addr_i == ADDR_POWER_MODE;
  assign hit_clock = reg_addr_i == ADDR_GLOBAL_CLOCK;
  assign hit_divide = reg_addr_i == ADDR_CLOCK_DIVIDE;
  assign hit_test = reg_addr_i == ADDR_OUTPUT_TEST;
  assign hit_bist = reg_addr_i == ADDR_SELF_TEST;
  assign hit_servo = reg_addr_i == ADDR_INPUT_SERVO;
  assign hit_trim = reg_addr_i == ADDR_OFFSET_TRIM;
  assign hit_format = reg_addr_i == ADDR_OUTPUT_FORMAT;

  // Reads of local registers come from channel A unless only B is selected
  assign rd_chan = (chan_sel_i == 2'b10);

  always_comb
  begin
    rdata_next = 8'h00;
    if (hit_power)
      rdata_next = power_mode_control_reg[rd_chan];
    else if (hit_clock)
      rdata_next = global_clock_control_reg;
    else if (hit_divide)
      rdata_next = clock_divide_control_reg;
    else if (hit_test)
      rdata_next = output_test_control_reg[rd_chan];
    else if (hit_bist)
      rdata_next = self_test_control_reg;
    else if (hit_servo)
      rdata_next = input_servo_control_reg;
    else if (hit_trim)
      rdata_next = offset_trim_reg[rd_chan];
    else if (hit_format)
      rdata_next = format_local_reg[rd_chan] | format_global_reg;
  end

  // Local register writes, gated per channel
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_local
    wire logic wr_ch;
    assign wr_ch = reg_wr_i && chan_sel_i[ch];

    always_ff @(posedge clk_i)
    begin
      if (reset_i)
      begin
        power_mode_control_reg[ch] <= RST_POWER_MODE;
        output_test_control_reg[ch] <= RST_OUTPUT_TEST;
        offset_trim_reg[ch] <= RST_OFFSET_TRIM;
        format_local_reg[ch] <= RST_OUTPUT_FORMAT & FMT_LOCAL_MASK;
      end
      else if (wr_ch)
      begin
        // Top bit of the power register always reads one
        if (hit_power)
          power_mode_control_reg[ch] <= reg_wdata_i | RST_POWER_MODE;
        if (hit_test)
          output_test_control_reg[ch] <= reg_wdata_i;
        if (hit_trim)
          offset_trim_reg[ch] <= reg_wdata_i;
        if (hit_format)
          format_local_reg[ch] <= reg_wdata_i & FMT_LOCAL_MASK;
      end
    end

    assign chan_cfg[ch].test_mode = acr_test_e'(output_test_control_reg[ch][2:0]);
    assign chan_cfg[ch].pn_long_rst = output_test_control_reg[ch][TST_PN_LONG_RST_BIT];
    assign chan_cfg[ch].pn_short_rst = output_test_control_reg[ch][TST_PN_SHORT_RST_BIT];
    assign chan_cfg[ch].offset = offset_trim_reg[ch];
    assign chan_cfg[ch].format = acr_format_e'(format_local_reg[ch][1:0]);
    assign chan_cfg[ch].invert = format_local_reg[ch][FMT_INVERT_BIT];

    assign shutdown_next[ch] = is_shutdown(power_mode_control_reg[ch], pdwn_pin_i);
    assign standby_next[ch] = is_standby(power_mode_control_reg[ch], pdwn_pin_i);

    acr_chan_path u_path
    (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .cfg_i(chan_cfg[ch]),
      .sample_en_i(div_sample_en),
      .hold_i(shutdown_next[ch] | standby_next[ch]),
      .conv_data_i(ch == 0 ? conv_data_a_i : conv_data_b_i),
      .out_data_o(path_data[ch])
    );
  end

  // Global register writes ignore the channel select
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      global_clock_control_reg <= RST_GLOBAL_CLOCK;
      clock_divide_control_reg <= RST_CLOCK_DIVIDE;
      self_test_control_reg <= RST_SELF_TEST;
      input_servo_control_reg <= RST_INPUT_SERVO;
      format_global_reg <= RST_OUTPUT_FORMAT & FMT_GLOBAL_MASK;
    end
    else if (reg_wr_i)
    begin
      if (hit_clock)
        global_clock_control_reg <= reg_wdata_i;
      if (hit_divide)
        clock_divide_control_reg <= reg_wdata_i;
      if (hit_bist)
        self_test_control_reg <= reg_wdata_i;
      if (hit_servo)
        input_servo_control_reg <= reg_wdata_i;
      if (hit_format)
        format_global_reg <= reg_wdata_i & FMT_GLOBAL_MASK;
    end
  end

  acr_clk_div u_div
  (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .div_code_i(clock_divide_control_reg[2:0]),
    .dcs_bit_i(global_clock_control_reg[CLK_DCS_BIT]),
    .sample_en_o(div_sample_en),
    .dcs_en_o(div_dcs_en)
  );

  // Output flops
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      reg_rdata_o <= 8'h00;
      shutdown_o <= 2'b00;
      standby_o <= 2'b00;
      out_enable_n_o <= 2'b00;
      out_data_a_o <= 14'h0000;
      out_data_b_o <= 14'h0000;
      sample_en_o <= 1'b0;
      dcs_en_o <= 1'b1;
      bist_en_o <= 1'b0;
      bist_reset_o <= 1'b1;
      servo_en_o <= 1'b0;
      drive_reduced_o <= 1'b0;
      output_lvds_o <= 1'b0;
      interleave_o <= 1'b0;
    end
    else
    begin
      reg_rdata_o <= rdata_next;
      shutdown_o <= shutdown_next;
      standby_o <= standby_next;
      out_enable_n_o <= {format_local_reg[1][FMT_OE_N_BIT], format_local_reg[0][FMT_OE_N_BIT]};
      out_data_a_o <= path_data[0];
      out_data_b_o <= path_data[1];
      sample_en_o <= div_sample_en;
      dcs_en_o <= div_dcs_en;
      bist_en_o <= self_test_control_reg[SELF_TEST_CONTROL_BIT];
      bist_reset_o <= self_test_control_reg[BIST_RESET_BIT];
      servo_en_o <= input_servo_control_reg[SERVO_ENABLE_BIT];
      drive_reduced_o <= format_global_reg[FMT_DRIVE_BIT];
      output_lvds_o <= format_global_reg[FMT_TYPE_BIT];
      interleave_o <= format_global_reg[FMT_INTERLEAVE_BIT];
    end
  end
endmodule
`default_nettype wire

// >>> tb/acr_top_asserts.sv
// Port-level assertions for the channel control bank
`timescale 1ns/1ps
`default_nettype none
module acr_top_asserts
  import acr_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Register port
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [1:0] chan_sel_i,
  input wire logic [7:0] reg_rdata_o,
  // Pin and channel state
  input wire logic pdwn_pin_i,
  input wire logic [1:0] shutdown_o,
  input wire logic [1:0] standby_o,
  input wire logic [1:0] out_enable_n_o,
  // Global controls
  input wire logic dcs_en_o,
  input wire logic bist_en_o,
  input wire logic servo_en_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  wire mapped = reg_addr_i inside {ADDR_POWER_MODE, ADDR_GLOBAL_CLOCK, ADDR_CLOCK_DIVIDE,
    ADDR_OUTPUT_TEST, ADDR_SELF_TEST, ADDR_INPUT_SERVO, ADDR_OFFSET_TRIM, ADDR_OUTPUT_FORMAT};
  wire wr_div = reg_wr_i && reg_addr_i == ADDR_CLOCK_DIVIDE && reg_wdata_i[2:0] != 3'h0;

  a_power_exclusive: assert property ((shutdown_o & standby_o) == 2'b00)
    else $error("shutdown and standby both set");
  a_fixed_bit_set: assert property (reg_addr_i == ADDR_POWER_MODE |=> reg_rdata_o[7])
    else $error("power mode fixed bit reads low");
  a_pin_forces_down: assert property (pdwn_pin_i [*3] |-> (shutdown_o | standby_o) == 2'b11)
    else $error("power-down pin ignored");
  a_divide_dcs_on: assert property (wr_div ##1 !reg_wr_i |=> ##1 dcs_en_o)
    else $error("stabilizer off with divide active");
  a_trim_read_back: assert property (reg_wr_i && reg_addr_i == ADDR_OFFSET_TRIM
    && chan_sel_i == 2'b01 ##1 !reg_wr_i && $stable(reg_addr_i) && chan_sel_i != 2'b10
    |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("trim readback wrong");
  a_servo_global: assert property (reg_wr_i && reg_addr_i == ADDR_INPUT_SERVO
    ##1 !reg_wr_i |=> servo_en_o == $past(reg_wdata_i[0], 2))
    else $error("servo enable not updated");
  a_bist_global: assert property (reg_wr_i && reg_addr_i == ADDR_SELF_TEST
    ##1 !reg_wr_i |=> bist_en_o == $past(reg_wdata_i[0], 2))
    else $error("self-test enable not updated");
  a_oe_both_chan: assert property (reg_wr_i && reg_addr_i == ADDR_OUTPUT_FORMAT
    && chan_sel_i == 2'b11 ##1 !reg_wr_i |=> out_enable_n_o == {2{$past(reg_wdata_i[4], 2)}})
    else $error("output enable not set on both channels");
  a_unmapped_zero: assert property (!mapped |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind acr_top acr_top_asserts i_acr_top_asserts (.clk_i, .reset_i, .reg_wr_i, .reg_addr_i,
  .reg_wdata_i, .chan_sel_i, .reg_rdata_o, .pdwn_pin_i, .shutdown_o, .standby_o,
  .out_enable_n_o, .dcs_en_o, .bist_en_o, .servo_en_o);
`default_nettype wire

// >>> tb/acr_top_test.sv
// Self-checking bench for the channel control bank
`timescale 1ns/1ps
`default_nettype none
module acr_top_test;
  import acr_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic reg_wr_i = 1'b0;
  logic pdwn_pin_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h08;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [1:0] chan_sel_i = 2'b01;
  logic [13:0] conv_data_a_i = 14'h1000;
  logic [13:0] conv_data_b_i = 14'h0800;
  logic [7:0] reg_rdata_o;
  logic [1:0] shutdown_o, standby_o, out_enable_n_o;
  logic [13:0] out_data_a_o, out_data_b_o;
  logic sample_en_o, dcs_en_o, bist_en_o, bist_reset_o, servo_en_o;
  logic drive_reduced_o, output_lvds_o, interleave_o;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  localparam logic [7:0] ADRS [8] = '{ADDR_POWER_MODE, ADDR_GLOBAL_CLOCK, ADDR_CLOCK_DIVIDE,
    ADDR_OUTPUT_TEST, ADDR_SELF_TEST, ADDR_INPUT_SERVO, ADDR_OFFSET_TRIM, ADDR_OUTPUT_FORMAT};
  localparam logic [7:0] RSTS [8] = '{8'h80, 8'h01, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00};

  always #5 clk_i = ~clk_i;

  acr_top i_acr_top (.clk_i, .reset_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i, .chan_sel_i,
    .reg_rdata_o, .pdwn_pin_i, .conv_data_a_i, .conv_data_b_i, .out_data_a_o, .out_data_b_o,
    .shutdown_o, .standby_o, .out_enable_n_o, .sample_en_o, .dcs_en_o, .bist_en_o,
    .bist_reset_o, .servo_en_o, .drive_reduced_o, .output_lvds_o, .interleave_o);

  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // One idle cycle between writes keeps each strobe a clean pulse
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] s);
    @(negedge clk_i);
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = d;
    chan_sel_i = s;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] s, input logic [7:0] exp);
    @(negedge clk_i);
    reg_addr_i = a;
    chan_sel_i = s;
    @(negedge clk_i);
    chk(14'(reg_rdata_o), 14'(exp));
  endtask

  task automatic t_reset;
    for (int i = 0; i < 8; i++)
      rd(ADRS[i], 2'b01, RSTS[i]);
    rd(8'h0c, 2'b01, 8'h00);
    chk(14'({dcs_en_o, bist_reset_o, bist_en_o, servo_en_o}), 14'h000c);
  endtask

  task automatic t_power;
    for (int m = 0; m < 4; m++)
    begin
      wr(ADDR_POWER_MODE, 8'(m), 2'b01);
      rd(ADDR_POWER_MODE, 2'b01, 8'h80 | 8'(m));
      cyc(2);
      chk(14'({shutdown_o[0], standby_o[0]}), 14'({m == 1, m == 2}));
    end
    wr(ADDR_POWER_MODE, 8'h80, 2'b01);
  endtask

  task automatic t_pin;
    wr(ADDR_POWER_MODE, 8'ha0, 2'b10);
    pdwn_pin_i = 1'b1;
    cyc(4);
    chk(14'({shutdown_o, standby_o}), 14'h0006);
    pdwn_pin_i = 1'b0;
    cyc(4);
    chk(14'({shutdown_o, standby_o}), 14'h0000);
    wr(ADDR_POWER_MODE, 8'h80, 2'b10);
  endtask

  task automatic t_div;
    int n;
    int codes [3] = '{0, 1, 7};
    // Stabilizer bit off, so only a nonzero divide code can turn it on
    wr(ADDR_GLOBAL_CLOCK, 8'h00, 2'b00);
    foreach (codes[k])
    begin
      wr(ADDR_CLOCK_DIVIDE, 8'(codes[k]), 2'b00);
      cyc(3);
      chk(14'(dcs_en_o), 14'(codes[k] != 0));
      n = 0;
      repeat (24)
      begin
        @(negedge clk_i);
        n += int'(sample_en_o === 1'b1);
      end
      chk(14'(n), 14'(24 / (codes[k] + 1)));
    end
    chk(14'(dcs_en_o), 14'h0001);
    wr(ADDR_CLOCK_DIVIDE, 8'h00, 2'b00);
    cyc(3);
    chk(14'(dcs_en_o), 14'h0000);
    wr(ADDR_GLOBAL_CLOCK, 8'h01, 2'b00);
  endtask

  task automatic t_pattern;
    logic [13:0] w0, w1;
    logic [2:0] code [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
    logic [13:0] lo [5] = '{14'h2000, 14'h3fff, 14'h0000, 14'h1555, 14'h0000};
    logic [13:0] hi [5] = '{14'h2000, 14'h3fff, 14'h0000, 14'h2aaa, 14'h3fff};
    for (int i = 0; i < 5; i++)
    begin
      wr(ADDR_OUTPUT_TEST, 8'(code[i]), 2'b01);
      cyc(4);
      w0 = out_data_a_o;
      cyc(1);
      w1 = out_data_a_o;
      chk(w0 ^ w1, lo[i] ^ hi[i]);
      chk((w0 < w1) ? w0 : w1, lo[i]);
      chk(out_data_b_o, 14'h0800);
    end
  endtask

  task automatic t_pn;
    logic [13:0] w0;
    for (int k = 0; k < 2; k++)
    begin
      wr(ADDR_OUTPUT_TEST, 8'(5 + k) | (8'h20 >> k), 2'b01);
      cyc(4);
      w0 = out_data_a_o;
      cyc(3);
      chk(out_data_a_o, w0);
      wr(ADDR_OUTPUT_TEST, 8'(5 + k), 2'b01);
      cyc(4);
      w0 = out_data_a_o;
      cyc(1);
      chk(14'(out_data_a_o !== w0), 14'h0001);
    end
    wr(ADDR_OUTPUT_TEST, 8'h00, 2'b01);
  endtask

  task automatic t_trim;
    logic [13:0] cv [4] = '{14'h1000, 14'h1000, 14'h3ff0, 14'h0010};
    logic [7:0] tr [4] = '{8'h7f, 8'h80, 8'h7f, 8'h80};
    logic [13:0] ex [4] = '{14'h107f, 14'h0f80, 14'h3fff, 14'h0000};
    for (int i = 0; i < 4; i++)
    begin
      conv_data_a_i = cv[i];
      wr(ADDR_OFFSET_TRIM, tr[i], 2'b01);
      cyc(4);
      chk(out_data_a_o, ex[i]);
      chk(out_data_b_o, 14'h0800);
    end
    conv_data_a_i = 14'h1000;
    wr(ADDR_OFFSET_TRIM, 8'h00, 2'b01);
    wr(ADDR_OFFSET_TRIM, 8'h7f, 2'b10);
    cyc(4);
    chk(out_data_a_o, 14'h1000);
    chk(out_data_b_o, 14'h087f);
    rd(ADDR_OFFSET_TRIM, 2'b10, 8'h7f);
    wr(ADDR_OFFSET_TRIM, 8'h00, 2'b11);
  endtask

  // Output coding on channel A only: two's complement, gray, inverted
  task automatic t_format;
    logic [7:0] fm [3] = '{8'h01, 8'h02, 8'h04};
    logic [13:0] ex [3] = '{14'h3000, 14'h1800, 14'h2fff};
    for (int i = 0; i < 3; i++)
    begin
      wr(ADDR_OUTPUT_FORMAT, fm[i], 2'b01);
      cyc(4);
      chk(out_data_a_o, ex[i]);
      chk(out_data_b_o, 14'h0800);
    end
    wr(ADDR_OUTPUT_FORMAT, 8'h00, 2'b11);
  endtask

  task automatic t_global;
    wr(ADDR_SELF_TEST, 8'h01, 2'b10);
    wr(ADDR_INPUT_SERVO, 8'h01, 2'b00);
    wr(ADDR_OUTPUT_FORMAT, 8'hf0, 2'b11);
    cyc(3);
    chk(14'({bist_en_o, bist_reset_o, servo_en_o}), 14'h0005);
    chk(14'({drive_reduced_o, output_lvds_o, interleave_o}), 14'h0007);
    chk(14'(out_enable_n_o), 14'h0003);
    rd(ADDR_OUTPUT_FORMAT, 2'b01, 8'hf0);
    wr(ADDR_OUTPUT_FORMAT, 8'h00, 2'b11);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Whole run is well under a thousand cycles
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      finish_test;
    end
  end

  initial
  begin
    repeat (4) @(negedge clk_i);
    reset_i = 1'b0;
    t_reset;
    t_power;
    t_pin;
    t_div;
    t_pattern;
    t_pn;
    t_trim;
    t_format;
    t_global;
    finish_test;
  end
endmodule
`default_nettype wire
